// [rtl/tcc_pkg.sv]
// Functional notes
// - Edge A still restarts soft one-shot.
// - Wrap flag sets on all-ones rollover.
// - Wrap flag clear ignored until count one.
// - Capture beats register write.
// - Both edges on A disables capture.
// - Capture select diverts edge B to irq.
// - Capture now, interrupt at next tick.
// - Compare-mode registers never capture.
// - Unsafe second rewrite may toggle repeatedly.
// - Edges judged against last recorded level.
// - Filter clock depends on edge use.
// - Event count starts after two edges.
// - Pattern period and width plus one.
// - Shared pin is input or output.
// - Soft trigger self-clears, reads zero.
// - One-shot active on high, off low.
package tcc_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_TRIG = 8'h04;
  localparam logic [7:0] A_STAT = 8'h08;
  localparam logic [7:0] A_CNT = 8'h0c;
  localparam logic [7:0] A_PER = 8'h10;
  localparam logic [7:0] A_SEC = 8'h14;
  // ---------------------------------------------------------------
  // Control fields
  // ---------------------------------------------------------------
  localparam int CTRL_W = 18;
  localparam int F_MODE = 0;
  localparam int F_ONESHOT = 2;
  localparam int F_PATTERN = 3;
  localparam int F_ESA = 4;
  localparam int F_ESB = 6;
  localparam int F_PRE = 8;
  localparam int F_EXT = 10;
  localparam int F_CAP_PER = 11;
  localparam int F_CAP_SEC = 12;
  localparam int F_CAP_BSEL = 13;
  localparam int F_INV_PER = 14;
  localparam int F_INV_SEC = 15;
  localparam int F_PIN_IN = 16;
  localparam int F_RSVD = 17;
  localparam logic [CTRL_W-1:0] CTRL_RST = 18'h10000;
  localparam int S_WRAP = 0;
  localparam int S_OUT = 1;
  localparam int T_SOFT = 0;
  // ---------------------------------------------------------------
  // Encodings and constants
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_STOP = 2'h0;
  localparam logic [1:0] MODE_EDGE_CLR = 2'h1;
  localparam logic [1:0] MODE_FREE = 2'h2;
  localparam logic [1:0] MODE_MATCH_CLR = 2'h3;
  localparam logic [1:0] ES_FALL = 2'h0;
  localparam logic [1:0] ES_RISE = 2'h1;
  localparam logic [1:0] ES_NONE = 2'h2;
  localparam logic [1:0] ES_BOTH = 2'h3;
  localparam logic [15:0] ALL_ONES = 16'hffff;
  localparam logic [15:0] REG_RST = 16'h0000;
  localparam logic [7:0] PRE_MASK [4] = '{8'h01, 8'h03, 8'h0f, 8'hff};
  typedef enum logic [1:0] {
    TCC_ARM_IDLE = 2'b00,
    TCC_ARM_ONE = 2'b01,
    TCC_ARM_RUN = 2'b11
  } tcc_arm_t;
endpackage

// [rtl/tcc_prescaler.sv]
`timescale 1ns/1ps
module tcc_prescaler (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Rate select and tick
  input wire logic [1:0] sel,
  output logic tick
);
  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } tcc_pre_t;

  tcc_pre_t s_r;
  tcc_pre_t s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.cnt = s_r.cnt + 8'h01;
    s_nxt.tick = (s_r.cnt & tcc_pkg::PRE_MASK[sel]) ==
                 tcc_pkg::PRE_MASK[sel];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign tick = s_r.tick;
endmodule

// [rtl/tcc_edge_filter.sv]
`timescale 1ns/1ps
module tcc_edge_filter (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pin and controls
  input wire logic pin_i,
  input wire logic sample_en,
  input wire logic run,
  // Detected edges
  output logic rise,
  output logic fall
);
  typedef struct packed {
    logic [2:0] sync;
    logic lvl;
    logic samp;
    logic filt;
    logic last;
    logic rise;
    logic fall;
  } tcc_flt_t;

  tcc_flt_t s_r;
  tcc_flt_t s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.sync = {s_r.sync[1:0], pin_i};
    if (s_r.sync[1] == s_r.sync[2])
      s_nxt.lvl = s_r.sync[2];
    // Level must be seen on two samples in a row
    if (sample_en)
    begin
      s_nxt.samp = s_r.lvl;
      if (s_r.samp == s_r.lvl)
        s_nxt.filt = s_r.lvl;
    end
    // Recorded level frozen while stopped, so a restart
    // reports whatever changed meanwhile
    s_nxt.rise = run & s_r.filt & ~s_r.last;
    s_nxt.fall = run & ~s_r.filt & s_r.last;
    if (run)
      s_nxt.last = s_r.filt;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign rise = s_r.rise;
  assign fall = s_r.fall;
endmodule

// [rtl/tcc_timer.sv]
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
module tcc_timer (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins
  input wire logic edge_input_a,
  input wire logic shared_port_pin_i,
  output logic timer_out_pin_o,
  output logic timer_out_pin_oe_n,
  // Match and capture events
  output logic match_irq_a,
  output logic match_irq_b
);
  typedef struct packed {
    logic [tcc_pkg::CTRL_W-1:0] ctrl;
    logic [15:0] cnt;
    logic [15:0] per;
    logic [15:0] sec;
    tcc_pkg::tcc_arm_t arm;
    logic wrap;
    logic wrap_hold;
    logic tout;
    logic os_act;
    logic soft_trig;
    logic pend_a;
    logic pend_b;
    logic irq_a;
    logic irq_b;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } tcc_state_t;

  tcc_state_t s_r;
  tcc_state_t s_nxt;

  logic pre_tick;
  logic a_rise;
  logic a_fall;
  logic b_rise;
  logic b_fall;
  logic run;
  logic ext;
  logic ea;
  logic eb;
  logic ea_cap;
  logic trig_a;
  logic os_trig;
  logic tick;
  logic clr_match;
  logic wrap_ev;
  logic m_per;
  logic m_sec;
  logic cap_per_ev;
  logic cap_sec_ev;
  logic wr;
  logic hit;

  function automatic logic edge_ok(input logic [1:0] es,
                                   input logic r,
                                   input logic f);
    logic res;
    res = 1'b0;
    case (es)
      tcc_pkg::ES_RISE: res = r;
      tcc_pkg::ES_FALL: res = f;
      tcc_pkg::ES_BOTH: res = r | f;
      default: res = 1'b0;
    endcase
    return res;
  endfunction

  // ---------------------------------------------------------------
  // Count clock and edge inputs
  // ---------------------------------------------------------------
  tcc_prescaler u_pre (
    .pclk(pclk),
    .presetn(presetn),
    .sel(s_r.ctrl[tcc_pkg::F_PRE +: 2]),
    .tick(pre_tick)
  );

  // Edge A samples every cycle when it is the count source
  tcc_edge_filter u_flt_a (
    .pclk(pclk),
    .presetn(presetn),
    .pin_i(edge_input_a),
    .sample_en(ext | pre_tick),
    .run(run),
    .rise(a_rise),
    .fall(a_fall)
  );

  tcc_edge_filter u_flt_b (
    .pclk(pclk),
    .presetn(presetn),
    .pin_i(shared_port_pin_i),
    .sample_en(pre_tick),
    .run(run),
    .rise(b_rise),
    .fall(b_fall)
  );

  // ---------------------------------------------------------------
  // Event decode
  // ---------------------------------------------------------------
  always_comb
  begin
    run = s_r.ctrl[tcc_pkg::F_MODE +: 2] != tcc_pkg::MODE_STOP;
    ext = s_r.ctrl[tcc_pkg::F_EXT];
    ea = edge_ok(s_r.ctrl[tcc_pkg::F_ESA +: 2], a_rise, a_fall);
    // Pin driven as output never feeds the edge logic
    eb = s_r.ctrl[tcc_pkg::F_PIN_IN] &
         edge_ok(s_r.ctrl[tcc_pkg::F_ESB +: 2], b_rise, b_fall);
    ea_cap = ea & ~ext &
             (s_r.ctrl[tcc_pkg::F_ESA +: 2] != tcc_pkg::ES_BOTH);
    trig_a = run & ea & ~ext;
    // Edge trigger stays live in soft one-shot use
    os_trig = run & s_r.ctrl[tcc_pkg::F_ONESHOT] &
              (s_r.soft_trig | trig_a);
    // Event counting waits for two armed edges
    tick = run & (ext ? (ea & (s_r.arm == tcc_pkg::TCC_ARM_RUN))
                      : pre_tick);
    clr_match = (s_r.ctrl[tcc_pkg::F_MODE +: 2] ==
                 tcc_pkg::MODE_MATCH_CLR | s_r.ctrl[tcc_pkg::F_PATTERN]) &
                (s_r.cnt == s_r.per);
    wrap_ev = tick & ~os_trig & (s_r.cnt == tcc_pkg::ALL_ONES);
    // Capture-mode registers are excluded from compare
    m_per = tick & (s_r.cnt == s_r.per) & ~s_r.ctrl[tcc_pkg::F_CAP_PER];
    m_sec = tick & (s_r.cnt == s_r.sec) & ~s_r.ctrl[tcc_pkg::F_CAP_SEC];
    cap_per_ev = run & s_r.ctrl[tcc_pkg::F_CAP_PER] &
                 (s_r.ctrl[tcc_pkg::F_CAP_BSEL] ? ea_cap : eb);
    cap_sec_ev = run & s_r.ctrl[tcc_pkg::F_CAP_SEC] & ea_cap;
    wr = psel & penable & s_r.pready & pwrite & ~s_r.pslverr;
    case (paddr)
      tcc_pkg::A_CTRL,
      tcc_pkg::A_TRIG,
      tcc_pkg::A_STAT,
      tcc_pkg::A_CNT,
      tcc_pkg::A_PER,
      tcc_pkg::A_SEC: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.soft_trig = 1'b0;
    s_nxt.irq_a = 1'b0;
    s_nxt.irq_b = 1'b0;
    s_nxt.pready = 1'b0;
    s_nxt.pslverr = 1'b0;

    if (!run)
      s_nxt.arm = tcc_pkg::TCC_ARM_IDLE;
    else if (ext & ea)
    begin
      unique case (s_r.arm)
        tcc_pkg::TCC_ARM_IDLE: s_nxt.arm = tcc_pkg::TCC_ARM_ONE;
        tcc_pkg::TCC_ARM_ONE: s_nxt.arm = tcc_pkg::TCC_ARM_RUN;
        tcc_pkg::TCC_ARM_RUN: s_nxt.arm = tcc_pkg::TCC_ARM_RUN;
        default: s_nxt.arm = tcc_pkg::TCC_ARM_IDLE;
      endcase
    end

    // Counter
    if (!run)
      s_nxt.cnt = tcc_pkg::REG_RST;
    else if (os_trig | (trig_a & (s_r.ctrl[tcc_pkg::F_MODE +: 2] ==
                                  tcc_pkg::MODE_EDGE_CLR)))
      s_nxt.cnt = tcc_pkg::REG_RST;
    else if (tick & clr_match)
      s_nxt.cnt = tcc_pkg::REG_RST;
    else if (tick)
      s_nxt.cnt = s_r.cnt + 16'h0001;

    // Overflow stays asserted until the count reaches one
    if (tick)
      s_nxt.wrap_hold = wrap_ev;
    if (wr & (paddr == tcc_pkg::A_STAT) & pwdata[tcc_pkg::S_WRAP])
      s_nxt.wrap = 1'b0;
    if (wrap_ev | s_r.wrap_hold)
      s_nxt.wrap = 1'b1;

    // Output pin
    if (os_trig)
    begin
      s_nxt.tout = 1'b0;
      s_nxt.os_act = 1'b1;
    end
    else if (s_r.ctrl[tcc_pkg::F_ONESHOT])
    begin
      // Smaller compare value starts the pulse, larger ends it
      if (s_r.os_act & ((s_r.per < s_r.sec) ? m_per : m_sec))
        s_nxt.tout = 1'b1;
      if (s_r.os_act & ((s_r.per < s_r.sec) ? m_sec : m_per))
      begin
        s_nxt.tout = 1'b0;
        s_nxt.os_act = 1'b0;
      end
    end
    else if (s_r.ctrl[tcc_pkg::F_PATTERN])
    begin
      // High over counts 0..second, period is period+1
      if (m_per)
        s_nxt.tout = 1'b1;
      else if (m_sec)
        s_nxt.tout = 1'b0;
    end
    else
      // Compares the live value, so a rewrite can re-hit
      s_nxt.tout = s_r.tout ^
                   (m_per & s_r.ctrl[tcc_pkg::F_INV_PER]) ^
                   (m_sec & s_r.ctrl[tcc_pkg::F_INV_SEC]);

    // Captures land at once, their events at the next tick
    if (cap_per_ev)
    begin
      s_nxt.per = s_r.cnt;
      s_nxt.pend_a = 1'b1;
    end
    if (cap_sec_ev)
    begin
      s_nxt.sec = s_r.cnt;
      s_nxt.pend_b = 1'b1;
    end
    if (run & eb & s_r.ctrl[tcc_pkg::F_CAP_BSEL])
      s_nxt.pend_a = 1'b1;
    if (pre_tick)
    begin
      s_nxt.pend_a = cap_per_ev |
                     (run & eb & s_r.ctrl[tcc_pkg::F_CAP_BSEL]);
      s_nxt.pend_b = cap_sec_ev;
    end
    s_nxt.irq_a = m_per | (pre_tick & s_r.pend_a);
    s_nxt.irq_b = m_sec | (pre_tick & s_r.pend_b);

    // APB setup phase: decode and latch read data
    if (psel & ~penable)
    begin
      s_nxt.pready = 1'b1;
      s_nxt.pslverr = ~hit;
      case (paddr)
        tcc_pkg::A_CTRL: s_nxt.prdata = 32'(s_r.ctrl);
        tcc_pkg::A_STAT: s_nxt.prdata = 32'({s_r.tout, s_r.wrap});
        tcc_pkg::A_CNT: s_nxt.prdata = 32'(s_r.cnt);
        tcc_pkg::A_PER: s_nxt.prdata = 32'(s_r.per);
        tcc_pkg::A_SEC: s_nxt.prdata = 32'(s_r.sec);
        default: s_nxt.prdata = 32'h0000_0000;
      endcase
    end

    // APB access phase writes; a capture beats a write
    if (wr)
    begin
      case (paddr)
        tcc_pkg::A_CTRL:
          s_nxt.ctrl = pwdata[tcc_pkg::CTRL_W-1:0] &
                       ~(18'(1) << tcc_pkg::F_RSVD);
        tcc_pkg::A_TRIG:
          s_nxt.soft_trig = pwdata[tcc_pkg::T_SOFT];
        tcc_pkg::A_PER:
          if (!cap_per_ev)
            s_nxt.per = pwdata[15:0];
        tcc_pkg::A_SEC:
          if (!cap_sec_ev)
            s_nxt.sec = pwdata[15:0];
        default: s_nxt.soft_trig = 1'b0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r <= '0;
      s_r.ctrl <= tcc_pkg::CTRL_RST;
      s_r.arm <= tcc_pkg::TCC_ARM_IDLE;
    end
    else
      s_r <= s_nxt;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign timer_out_pin_o = s_r.tout;
  assign timer_out_pin_oe_n = s_r.ctrl[tcc_pkg::F_PIN_IN];
  assign match_irq_a = s_r.irq_a;
  assign match_irq_b = s_r.irq_b;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_trig_self_clear: assert property (
    s_r.soft_trig |=> !s_r.soft_trig)
    else $error("soft trigger did not self clear");

  chk_edge_restarts: assert property (
    os_trig |=> s_r.cnt == 16'h0000 && s_r.os_act)
    else $error("edge trigger did not restart one-shot");

  chk_wrap_sets: assert property (
    wrap_ev |=> s_r.wrap && s_r.cnt == 16'h0000)
    else $error("wrap flag not set on rollover");

  chk_wrap_clear_blocked: assert property (
    s_r.wrap_hold |=> s_r.wrap)
    else $error("wrap flag clear took effect too early");

  chk_count_step: assert property (
    tick && !os_trig && !clr_match && !trig_a
    |=> s_r.cnt == $past(s_r.cnt) + 16'h0001)
    else $error("counter did not step by one");

  chk_cap_irq_next: assert property (
    pre_tick && s_r.pend_a |=> s_r.irq_a)
    else $error("capture event not raised at next tick");

  chk_no_both_cap: assert property (
    run && ea && s_r.ctrl[tcc_pkg::F_ESA +: 2] == tcc_pkg::ES_BOTH &&
    !(wr && paddr == tcc_pkg::A_SEC) |=> $stable(s_r.sec))
    else $error("capture with both edges selected");

  chk_bsel_no_cap: assert property (
    run && eb && s_r.ctrl[tcc_pkg::F_CAP_BSEL] && !ea_cap &&
    !(wr && paddr == tcc_pkg::A_PER)
    |=> $stable(s_r.per) && s_r.pend_a)
    else $error("edge B captured or lost its event");

  chk_pattern_rise: assert property (
    s_r.ctrl[tcc_pkg::F_PATTERN] && !s_r.ctrl[tcc_pkg::F_ONESHOT] && m_per
    && !os_trig |=> s_r.tout && s_r.cnt == 16'h0000)
    else $error("pattern output did not restart high");

  chk_oneshot_on: assert property (
    s_r.ctrl[tcc_pkg::F_ONESHOT] && s_r.os_act && !os_trig &&
    ((s_r.per < s_r.sec) ? m_per && !m_sec : m_sec && !m_per)
    |=> s_r.tout)
    else $error("one-shot did not go active");

  cov_wrap: cover property (wrap_ev ##1 s_r.wrap);
  cov_oneshot: cover property ($fell(s_r.os_act));
  cov_capture: cover property (cap_per_ev ##[1:300] s_r.irq_a);
  cov_pattern: cover property (
    s_r.ctrl[tcc_pkg::F_PATTERN] && $rose(s_r.tout));
endmodule

// [verification/tcc_pulse_src.sv]
`timescale 1ns/1ps
module tcc_pulse_src (
  // Clock
  input wire logic pclk,
  // Block pins
  input wire logic out_o,
  input wire logic out_oe_n,
  output logic edge_a,
  output logic pin_b
);
  logic b_drv;

  initial
  begin
    edge_a = 1'b0;
    b_drv = 1'b0;
  end

  // ---------------------------------------------------------------
  // Shared wire: source drives it only while the block listens
  // ---------------------------------------------------------------
  assign pin_b = out_oe_n ? b_drv : out_o;

  // ---------------------------------------------------------------
  // Sources
  // ---------------------------------------------------------------
  // Width kept above two count clocks, never a retrigger mid-pulse
  task automatic pulse(input bit sel_b, input int hi, input int lo);
    @(posedge pclk);
    level(sel_b, 1'b1);
    repeat (hi) @(posedge pclk);
    level(sel_b, 1'b0);
    repeat (lo) @(posedge pclk);
  endtask

  task automatic level(input bit sel_b, input logic v);
    if (sel_b)
      b_drv <= v;
    else
      edge_a <= v;
  endtask
endmodule

// [verification/tcc_timer_tb_top.sv]
`timescale 1ns/1ps
module tcc_timer_tb_top;
  localparam int PIN = 1 << tcc_pkg::F_PIN_IN;
  localparam int CSEC = 1 << tcc_pkg::F_CAP_SEC;
  localparam int CPER = 1 << tcc_pkg::F_CAP_PER;
  localparam int BSEL = 1 << tcc_pkg::F_CAP_BSEL;
  localparam int INV = (1 << tcc_pkg::F_INV_PER) | (1 << tcc_pkg::F_INV_SEC);
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic edge_a;
  logic pin_b;
  logic out_o;
  logic out_oe_n;
  logic irq_a;
  logic irq_b;
  logic [31:0] rd;
  logic er;
  int error_cnt = 0;
  int check_count = 0;
  int seed = 3;
  int na = 0;
  int nb = 0;
  int mdl [6];

  always #25 pclk = ~pclk;

  tcc_timer dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .edge_input_a(edge_a), .shared_port_pin_i(pin_b),
    .timer_out_pin_o(out_o), .timer_out_pin_oe_n(out_oe_n),
    .match_irq_a(irq_a), .match_irq_b(irq_b)
  );

  tcc_pulse_src src (
    .pclk(pclk), .out_o(out_o), .out_oe_n(out_oe_n),
    .edge_a(edge_a), .pin_b(pin_b)
  );

  always @(posedge pclk)
  begin
    if (irq_a === 1'b1)
      na <= na + 1;
    if (irq_b === 1'b1)
      nb <= nb + 1;
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    if (error_cnt == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    // Waits for the answer; only the watchdog ends a hung transfer
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
    case (a)
      tcc_pkg::A_CTRL: mdl[0] = d & 32'h1ffff;
      tcc_pkg::A_PER: mdl[4] = d & 32'hffff;
      tcc_pkg::A_SEC: mdl[5] = d & 32'hffff;
      default: ;
    endcase
  endtask

  // Length of the next run of the output at level lv, in pclk cycles
  task automatic run_len(input logic lv, output int n);
    n = 0;
    while (out_o !== lv && n < 5000)
    begin
      @(posedge pclk);
      n++;
    end
    n = 0;
    while (out_o === lv && n < 5000)
    begin
      @(posedge pclk);
      n++;
    end
  endtask

  function automatic logic [31:0] cf(int md, int esa, int esb, int fl);
    return 32'(md | (esa << tcc_pkg::F_ESA) | (esb << tcc_pkg::F_ESB) | fl);
  endfunction

  initial
  begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    final_report();
  end

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial
  begin
    int c1;
    int k;
    int s;
    int p;
    int h;
    int l;
    mdl = '{32'h10000, 0, 0, 0, 0, 0};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check(out_oe_n, 1'b1);
    for (int i = 0; i < 6; i++)
    begin
      apb(8'(i * 4), 1'b0, 32'h0);
      check({er, rd}, {1'b0, 32'(mdl[i])});
    end
    apb(8'h20, 1'b0, 32'h0);
    check({er, rd}, {1'b1, 32'h0});
    wr(tcc_pkg::A_CTRL, 32'h30000);
    apb(tcc_pkg::A_CTRL, 1'b0, 32'h0);
    check(rd, mdl[0]);
    // Count rate for every prescale setting, 8 ticks per window
    for (int i = 0; i < 4; i++)
    begin
      wr(tcc_pkg::A_CTRL, cf(2, 2, 2, PIN) | 32'(i << tcc_pkg::F_PRE));
      apb(tcc_pkg::A_CNT, 1'b0, 32'h0);
      c1 = rd;
      repeat (8 * (tcc_pkg::PRE_MASK[i] + 1) - 3) @(posedge pclk);
      apb(tcc_pkg::A_CNT, 1'b0, 32'h0);
      check(rd - c1, 8);
      wr(tcc_pkg::A_CTRL, PIN);
    end
    // Pattern values kept in 0 < second < period
    s = 2 + ($random(seed) & 3);
    p = s + 3 + ($random(seed) & 7);
    wr(tcc_pkg::A_PER, p);
    wr(tcc_pkg::A_SEC, s);
    wr(tcc_pkg::A_CTRL, cf(3, 2, 2, (1 << tcc_pkg::F_PATTERN) | INV));
    @(posedge pclk);
    check(out_oe_n, 1'b0);
    run_len(1'b1, h);
    run_len(1'b1, h);
    run_len(1'b0, l);
    check(h + l, 2 * (p + 1));
    check(h, 2 * (s + 1));
    // Compare values are only rewritten while stopped
    wr(tcc_pkg::A_CTRL, 32'h0);
    wr(tcc_pkg::A_PER, 40);
    wr(tcc_pkg::A_SEC, 10);
    wr(tcc_pkg::A_CTRL, cf(2, 2, 2, (1 << tcc_pkg::F_ONESHOT) | INV));
    wr(tcc_pkg::A_TRIG, 1);
    // Output may still be high from the pattern run: skip the lead-in
    run_len(1'b0, l);
    run_len(1'b1, h);
    check(h, 60);
    apb(tcc_pkg::A_TRIG, 1'b0, 32'h0);
    check(rd, 0);
    // Edge A starts a one-shot as well, with no soft trigger written
    wr(tcc_pkg::A_CTRL, 32'h0);
    wr(tcc_pkg::A_CTRL, cf(2, 1, 2, (1 << tcc_pkg::F_ONESHOT) | INV));
    src.pulse(1'b0, 8, 0);
    run_len(1'b0, l);
    run_len(1'b1, h);
    check(h, 60);
    wr(tcc_pkg::A_CTRL, PIN);
    wr(tcc_pkg::A_SEC, 32'h1234);
    k = nb;
    wr(tcc_pkg::A_CTRL, cf(2, 1, 2, PIN));
    src.pulse(1'b0, 8, 8);
    apb(tcc_pkg::A_SEC, 1'b0, 32'h0);
    check(rd, 32'h1234);
    wr(tcc_pkg::A_CTRL, PIN);
    wr(tcc_pkg::A_CTRL, cf(2, 3, 2, PIN | CSEC));
    src.pulse(1'b0, 8, 8);
    src.pulse(1'b0, 8, 8);
    apb(tcc_pkg::A_SEC, 1'b0, 32'h0);
    check(rd, 32'h1234);
    check(nb - k, 0);
    wr(tcc_pkg::A_CTRL, PIN);
    wr(tcc_pkg::A_CTRL, cf(2, 1, 2, PIN | CSEC));
    src.pulse(1'b0, 8, 8);
    apb(tcc_pkg::A_SEC, 1'b0, 32'h0);
    check(rd < 32'h40, 1'b1);
    check(nb - k, 1);
    // Pin raised while stopped is seen as a rising edge on restart
    wr(tcc_pkg::A_CTRL, PIN);
    src.level(1'b0, 1'b1);
    // Let the filter settle while stopped, so only the frozen level
    // can produce the edge on restart
    repeat (12) @(posedge pclk);
    wr(tcc_pkg::A_CTRL, cf(2, 1, 2, PIN | CSEC));
    repeat (20) @(posedge pclk);
    check(nb - k, 2);
    src.level(1'b0, 1'b0);
    wr(tcc_pkg::A_CTRL, PIN);
    wr(tcc_pkg::A_PER, 32'h0abc);
    k = na;
    wr(tcc_pkg::A_CTRL, cf(2, 2, 1, PIN | CPER | BSEL));
    src.pulse(1'b1, 8, 8);
    apb(tcc_pkg::A_PER, 1'b0, 32'h0);
    check(rd, 32'h0abc);
    check(na - k, 1);
    wr(tcc_pkg::A_CTRL, PIN);
    k = 3 + ($random(seed) & 3);
    wr(tcc_pkg::A_CTRL, cf(2, 1, 2, PIN | (1 << tcc_pkg::F_EXT)));
    repeat (k) src.pulse(1'b0, 6, 6);
    apb(tcc_pkg::A_CNT, 1'b0, 32'h0);
    check(rd, k - 2);
    wr(tcc_pkg::A_CTRL, PIN);
    final_report();
  end
endmodule
